/* common/dpc_pkg.sv */
// Constants and carrier types for the diagnostic and power capability registers
package dpc_pkg;

   // ---------------------------------------------------------------
   // Register offsets (configuration space byte addresses)
   // ---------------------------------------------------------------
   localparam logic [7:0] OFS_IDENT = 8'h00;
   localparam logic [7:0] OFS_DIAG = 8'h93;
   localparam logic [7:0] OFS_CAP_ID = 8'hA0;
   localparam logic [7:0] OFS_NEXT_PTR = 8'hA1;
   localparam logic [7:0] OFS_PWR_CAP = 8'hA2;

   // ---------------------------------------------------------------
   // Diagnostic control fields
   // ---------------------------------------------------------------
   localparam int DIAG_ID_MASK_BIT = 7;
   localparam int DIAG_RO_ONE_BIT = 6;
   localparam int DIAG_CSC_ROUTE_BIT = 5;
   localparam int DIAG_DT_DIS_BIT = 4;
   localparam int DIAG_RETRY_EXT_BIT = 3;
   localparam int DIAG_CARD_DISC_BIT = 2;
   localparam int DIAG_HOST_DISC_BIT = 1;
   localparam logic [7:0] DIAG_RST = 8'h60;
   localparam logic [7:0] DIAG_RO_ONES = 8'h40;
   localparam logic [7:0] DIAG_RW_MASK = 8'hBF;

   // ---------------------------------------------------------------
   // Capability header and power capabilities word
   // ---------------------------------------------------------------
   localparam logic [7:0] CAP_ID_VAL = 8'h01;
   localparam logic [7:0] NEXT_PTR_VAL = 8'h00;
   localparam logic [15:0] PWR_CAP_RST = 16'hFE12;
   localparam int PWR_CAP_WAKE_COLD_BIT = 15;
   localparam int PWR_CAP_BYTE_HI = 3;

   // ---------------------------------------------------------------
   // Legacy socket routing match and timing counts
   // ---------------------------------------------------------------
   localparam logic [3:0] LEG805_ROUTE_VAL = 4'h0;
   localparam logic [6:0] RETRY_SHORT_CYC = 7'h10;
   localparam logic [6:0] RETRY_LONG_CYC = 7'h40;
   localparam int DISC_SHORT_EXP = 10;
   localparam int DISC_LONG_EXP = 15;
   localparam int DISC_SHORT_CYC = 2 ** DISC_SHORT_EXP;
   localparam int DISC_LONG_CYC = 2 ** DISC_LONG_EXP;
   localparam int DISC_HOST = 0;
   localparam int DISC_CARD = 1;

   // ---------------------------------------------------------------
   // Carriers
   // ---------------------------------------------------------------
   typedef struct packed {
      logic rd;
      logic wr;
      logic [7:0] addr;
      logic [3:0] be;
      logic [31:0] wdata;
   } dpc_cfg_req_s;

   typedef struct packed {
      logic valid;
      logic [31:0] rdata;
   } dpc_cfg_rsp_s;

   typedef struct packed {
      logic delayed_txn_en;
      logic [6:0] retry_limit;
      logic pme_d3cold_en;
   } dpc_ctl_s;

   typedef struct packed {
      logic [7:0] diag;
      logic wake_cold;
      dpc_cfg_rsp_s rsp;
      dpc_ctl_s ctl;
      logic csc_irq;
      logic [6:0] retry_cnt;
      logic retry_expire;
      logic [1:0] disc_run;
      logic [1:0][15:0] disc_cnt;
      logic [1:0] disc_expire;
   } dpc_state_s;

endpackage

/* design/dpc_regs.sv */
// Diagnostic control, power capability header and their timer logic
// Function
// - Identity mask bit returns all-ones identity
// - Diagnostic bit 6 reads one, read-only
// - Routing zero: status change needs 803 bit4
// - Routing one: status change needs 805 nibble zero
// - Diagnostic bit 4 disables delayed transactions
// - Diagnostic bit 3 extends retry limit 16->64
// - Bit 2 selects card-side discard length
// - Bit 1 selects host-side discard length
// - Only global reset resets diagnostic bits, loading 60h
// - Capability identifier reads 01h, read-only
// - Next capability pointer reads zero, read-only
// - Power capabilities word resets to FE12h
// - Wake-support field defaults to all ones
// - Cold-D3 wake bit writable; firmware clears
// - Wake bits 14..11 read-only ones
// - D2_state_support bit reads one, read-only
`timescale 1ns/10ps
module dpc_regs #(
   parameter logic [15:0] VENDOR_ID = 16'h1234, // Arbitrary value
   parameter logic [15:0] DEVICE_ID = 16'h5678, // Arbitrary value
   parameter int DISC_LONG = dpc_pkg::DISC_LONG_CYC,
   parameter int DISC_SHORT = dpc_pkg::DISC_SHORT_CYC
) (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire logic pm_state_rst,
   input wire dpc_pkg::dpc_cfg_req_s cfg_req,
   output dpc_pkg::dpc_cfg_rsp_s cfg_rsp,
   input wire logic csc_event,
   input wire logic leg803_bit4,
   input wire logic [3:0] leg805_hi,
   output logic csc_irq_pci,
   input wire logic retry_wait,
   input wire logic [1:0] disc_start,
   input wire logic [1:0] disc_done,
   output logic retry_expire,
   output logic [1:0] disc_expire,
   output dpc_pkg::dpc_ctl_s ctl
);

   // ---------------------------------------------------------------
   // Address decode
   // ---------------------------------------------------------------
   function automatic logic dw_hit(input logic [7:0] a, input logic [7:0] ofs);
      dw_hit = (a[7:2] == ofs[7:2]);
   endfunction

   function automatic logic [15:0] disc_len(input logic short_sel);
      if (short_sel) begin
         disc_len = 16'(DISC_SHORT - 1);
      end else begin
         disc_len = 16'(DISC_LONG - 1);
      end
   endfunction

   dpc_pkg::dpc_state_s st_q;
   dpc_pkg::dpc_state_s st_d;

   logic [15:0] pwr_cap;
   logic [31:0] rd_word;
   logic [1:0] disc_sel;
   logic csc_route;

   // ---------------------------------------------------------------
   // Read values
   // ---------------------------------------------------------------
   always_comb begin
      pwr_cap = {st_q.wake_cold, dpc_pkg::PWR_CAP_RST[14:0]};
      disc_sel[dpc_pkg::DISC_HOST] = st_q.diag[dpc_pkg::DIAG_HOST_DISC_BIT];
      disc_sel[dpc_pkg::DISC_CARD] = st_q.diag[dpc_pkg::DIAG_CARD_DISC_BIT];
      if (st_q.diag[dpc_pkg::DIAG_CSC_ROUTE_BIT]) begin
         csc_route = (leg805_hi == dpc_pkg::LEG805_ROUTE_VAL);
      end else begin
         csc_route = leg803_bit4;
      end
      if (dw_hit(cfg_req.addr, dpc_pkg::OFS_IDENT)) begin
         if (st_q.diag[dpc_pkg::DIAG_ID_MASK_BIT]) begin
            rd_word = 32'hFFFFFFFF;
         end else begin
            rd_word = {DEVICE_ID, VENDOR_ID};
         end
      end else if (dw_hit(cfg_req.addr, dpc_pkg::OFS_DIAG)) begin
         rd_word = {st_q.diag | dpc_pkg::DIAG_RO_ONES, 24'h000000};
      end else if (dw_hit(cfg_req.addr, dpc_pkg::OFS_CAP_ID)) begin
         rd_word = {pwr_cap, dpc_pkg::NEXT_PTR_VAL, dpc_pkg::CAP_ID_VAL};
      end else begin
         rd_word = 32'h00000000;
      end
   end

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      st_d.rsp.valid = cfg_req.rd;
      if (cfg_req.rd) begin
         st_d.rsp.rdata = rd_word;
      end
      if (cfg_req.wr && cfg_req.be[3]) begin
         if (dw_hit(cfg_req.addr, dpc_pkg::OFS_DIAG)) begin
            st_d.diag = (cfg_req.wdata[31:24] & dpc_pkg::DIAG_RW_MASK)
               | dpc_pkg::DIAG_RO_ONES;
         end else if (dw_hit(cfg_req.addr, dpc_pkg::OFS_PWR_CAP)) begin
            st_d.wake_cold = cfg_req.wdata[31];
         end
      end

      st_d.csc_irq = csc_event && csc_route;

      st_d.ctl.delayed_txn_en = !st_q.diag[dpc_pkg::DIAG_DT_DIS_BIT];
      st_d.ctl.retry_limit = st_q.diag[dpc_pkg::DIAG_RETRY_EXT_BIT] ?
         dpc_pkg::RETRY_LONG_CYC : dpc_pkg::RETRY_SHORT_CYC;
      st_d.ctl.pme_d3cold_en = st_q.wake_cold;

      // Retry latency: counts waited cycles, one pulse at the limit
      st_d.retry_expire = 1'b0;
      if (!retry_wait || !st_q.ctl.delayed_txn_en) begin
         st_d.retry_cnt = 7'h00;
      end else if (st_q.retry_cnt != st_q.ctl.retry_limit) begin
         st_d.retry_cnt = st_q.retry_cnt + 7'h01;
         st_d.retry_expire = (st_q.retry_cnt == st_q.ctl.retry_limit - 7'h01);
      end

      // Discard timers, index 0 host side, 1 card side
      for (int i = 0; i < 2; i++) begin
         st_d.disc_expire[i] = 1'b0;
         if (disc_done[i] || !st_q.ctl.delayed_txn_en) begin
            st_d.disc_run[i] = 1'b0;
            st_d.disc_cnt[i] = 16'h0000;
         end else if (disc_start[i]) begin
            st_d.disc_run[i] = 1'b1;
            st_d.disc_cnt[i] = 16'h0000;
         end else if (st_q.disc_run[i]) begin
            if (st_q.disc_cnt[i] == disc_len(disc_sel[i])) begin
               st_d.disc_run[i] = 1'b0;
               st_d.disc_expire[i] = 1'b1;
            end else begin
               st_d.disc_cnt[i] = st_q.disc_cnt[i] + 16'h0001;
            end
         end
      end

      // Power-state reset stops transfers but keeps register bits
      if (pm_state_rst) begin
         st_d.disc_run = 2'b00;
         st_d.disc_cnt = '0;
         st_d.retry_cnt = 7'h00;
      end
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (sys_rst) begin
         st_q <= '0;
         st_q.diag <= dpc_pkg::DIAG_RST;
         st_q.wake_cold <= dpc_pkg::PWR_CAP_RST[dpc_pkg::PWR_CAP_WAKE_COLD_BIT];
         st_q.ctl.delayed_txn_en <= 1'b1;
         st_q.ctl.retry_limit <= dpc_pkg::RETRY_SHORT_CYC;
         st_q.ctl.pme_d3cold_en <= 1'b1;
      end else begin
         st_q <= st_d;
      end
   end

   assign cfg_rsp = st_q.rsp;
   assign csc_irq_pci = st_q.csc_irq;
   assign retry_expire = st_q.retry_expire;
   assign disc_expire = st_q.disc_expire;
   assign ctl = st_q.ctl;

endmodule // dpc_regs

/* testbench/dpc_regs_chk.sv */
// Port assertions for the register block
`timescale 1ns/10ps
module dpc_regs_chk (
   input wire logic ref_clk,
   input wire logic sys_rst,
   input wire dpc_pkg::dpc_cfg_req_s cfg_req,
   input wire dpc_pkg::dpc_cfg_rsp_s cfg_rsp,
   input wire logic csc_event,
   input wire logic leg803_bit4,
   input wire logic [3:0] leg805_hi,
   input wire logic csc_irq_pci,
   input wire logic retry_wait,
   input wire logic retry_expire,
   input wire dpc_pkg::dpc_ctl_s ctl
);
   // ---------
   // Checks
   // ---------
   default clocking @(posedge ref_clk);
   endclocking
   default disable iff (sys_rst);
   wire logic rd_diag = cfg_req.rd && cfg_req.addr[7:2] == 6'h24;
   wire logic rd_cap = cfg_req.rd && cfg_req.addr[7:2] == 6'h28;
   diag_fixed_a: assert property (rd_diag |=> cfg_rsp.rdata[30] && !cfg_rsp.rdata[23:0])
      else $error("diag fixed bits wrong");
   cap_header_a: assert property (rd_cap |=> cfg_rsp.rdata[15:0] == 16'h0001)
      else $error("cap header wrong");
   pwr_fixed_a: assert property (rd_cap |=> cfg_rsp.rdata[30:16] == 15'h7E12)
      else $error("pwr fixed bits wrong");
   csc_both_a: assert property (csc_event && leg803_bit4 && !leg805_hi |=> csc_irq_pci)
      else $error("csc not routed");
   csc_none_a: assert property (csc_event && !leg803_bit4 && leg805_hi |=> !csc_irq_pci)
      else $error("csc wrongly routed");
   csc_quiet_a: assert property (!csc_event |=> !csc_irq_pci)
      else $error("csc without event");
   dt_off_a: assert property (!ctl.delayed_txn_en && !$past(ctl.delayed_txn_en) |-> !retry_expire)
      else $error("retry while disabled");
   retry_span_a: assert property (retry_expire |-> $past(retry_wait, 16))
      else $error("retry expired early");
endmodule // dpc_regs_chk
bind dpc_regs dpc_regs_chk i_dpc_regs_chk (.ref_clk(ref_clk), .sys_rst(sys_rst), .ctl(ctl),
   .cfg_req(cfg_req), .cfg_rsp(cfg_rsp), .csc_event(csc_event), .leg803_bit4(leg803_bit4),
   .leg805_hi(leg805_hi), .csc_irq_pci(csc_irq_pci), .retry_wait(retry_wait),
   .retry_expire(retry_expire));

/* testbench/dpc_host.sv */
// Host model issuing configuration accesses
`timescale 1ns/10ps
module dpc_host (
   input wire logic ref_clk,
   output dpc_pkg::dpc_cfg_req_s cfg_req,
   input wire dpc_pkg::dpc_cfg_rsp_s cfg_rsp
);
   // ---------
   // Access
   // ---------
   initial cfg_req = '0;
   task automatic xfer(input logic w, input logic [7:0] a, input logic [3:0] be,
      input logic [31:0] v, output logic [31:0] d);
      @(posedge ref_clk);
      #1;
      cfg_req = '{rd: !w, wr: w, addr: a, be: be, wdata: v};
      @(posedge ref_clk);
      #1;
      // Released strobe, address and data lines stop showing old values; byte enables keep theirs
      cfg_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, be: be, wdata: ~v};
      d = (cfg_rsp.valid === 1'b1) ? cfg_rsp.rdata : 'x;
   endtask
endmodule // dpc_host

/* testbench/testbench.sv */
// Register access test sequence
`timescale 1ns/10ps
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
   $display("Error at %0t: got %h exp %h", $time, a, b); end end
module testbench;
   localparam int SHT = 8;
   localparam int LNG = 64;
   logic ref_clk = 1'b0;
   logic sys_rst = 1'b1;
   logic pm_state_rst = 1'b0;
   logic csc_event = 1'b0;
   logic leg803_bit4 = 1'b0;
   logic [3:0] leg805_hi = 4'h0;
   logic retry_wait = 1'b0;
   logic [1:0] disc_start = 2'h0;
   logic csc_irq_pci;
   logic retry_expire;
   logic [1:0] disc_expire;
   logic [31:0] d;
   dpc_pkg::dpc_cfg_req_s cfg_req;
   dpc_pkg::dpc_cfg_rsp_s cfg_rsp;
   dpc_pkg::dpc_ctl_s ctl;
   int err_total = 0;
   int check_count = 0;
   initial begin
      forever #5 ref_clk = ~ref_clk;
   end
   dpc_host i_dpc_host (.ref_clk(ref_clk), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp));
   dpc_regs #(.DISC_LONG(LNG), .DISC_SHORT(SHT)) i_dpc_regs (.ref_clk(ref_clk),
      .sys_rst(sys_rst), .pm_state_rst(pm_state_rst), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
      .csc_event(csc_event), .leg803_bit4(leg803_bit4), .leg805_hi(leg805_hi),
      .csc_irq_pci(csc_irq_pci), .retry_wait(retry_wait), .disc_start(disc_start),
      .disc_done(2'h0), .retry_expire(retry_expire), .disc_expire(disc_expire), .ctl(ctl));
   // ---------
   // Tasks
   // ---------
   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask
   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      i_dpc_host.xfer(1'b0, a, 4'h0, 32'h0, d);
      `CHK(d, e)
   endtask
   task automatic wd(input logic [7:0] v);
      i_dpc_host.xfer(1'b1, 8'h90, 4'h8, {v, 24'h0}, d);
   endtask
   task automatic status_change_routing(input logic l3, input logic [3:0] l5, input logic e);
      step(1);
      leg803_bit4 = l3;
      leg805_hi = l5;
      csc_event = 1'b1;
      step(1);
      csc_event = 1'b0;
      `CHK(csc_irq_pci, e)
   endtask
   task automatic run(input int s, input int e);
      int k;
      step(2);
      if (s < 2) disc_start[s] = 1'b1;
      else retry_wait = 1'b1;
      for (k = 1; k < 300; k++) begin
         step(1);
         disc_start = 2'h0;
         if ((s < 2 ? disc_expire[s] : retry_expire) === 1'b1) break;
      end
      retry_wait = 1'b0;
      `CHK(k, e)
      if (k == 300) end_of_test();
   endtask
   task automatic end_of_test();
      if (err_total == 0 && check_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      step(3);
      sys_rst = 1'b0;
      rc(8'h90, 32'h60000000);
      rc(8'hA0, 32'hFE120001);
      rc(8'h00, 32'h56781234);
      rc(8'h50, 32'h0);
      i_dpc_host.xfer(1'b1, 8'h90, 4'h7, 32'hFFFFFFFF, d);
      rc(8'h90, 32'h60000000);
      wd(8'h9E);
      rc(8'h90, 32'hDE000000);
      rc(8'h00, 32'hFFFFFFFF);
      `CHK(ctl.delayed_txn_en, 1'b0)
      `CHK(ctl.retry_limit, 7'h40)
      status_change_routing(1'b1, 4'hF, 1'b1);
      status_change_routing(1'b0, 4'h0, 1'b0);
      pm_state_rst = 1'b1;
      step(1);
      pm_state_rst = 1'b0;
      rc(8'h90, 32'hDE000000);
      wd(8'h26);
      run(0, SHT + 1);
      run(1, SHT + 1);
      status_change_routing(1'b0, 4'h0, 1'b1);
      status_change_routing(1'b1, 4'h1, 1'b0);
      status_change_routing(1'b1, 4'h0, 1'b1);
      status_change_routing(1'b0, 4'h3, 1'b0);
      wd(8'h20);
      run(0, LNG + 1);
      run(1, LNG + 1);
      run(2, 16);
      wd(8'h28);
      run(2, 64);
      i_dpc_host.xfer(1'b1, 8'hA0, 4'hF, 32'h0000FFFE, d);
      rc(8'hA0, 32'h7E120001);
      `CHK(ctl.pme_d3cold_en, 1'b0)
      sys_rst = 1'b1;
      step(3);
      sys_rst = 1'b0;
      rc(8'h90, 32'h60000000);
      rc(8'hA0, 32'hFE120001);
      end_of_test();
   end
endmodule // testbench
